// ==== logic/adc_conversion_power_control.sv ====
// conversion start, power-up and busy sequencer for a 10-bit sar converter
`timescale 1ns/1ps
module adc_conversion_power_control #(
	parameter int PWRUP_CYCLES = conv_ctrl_pkg::PWRUP_CYC,
	parameter int CONV_CYCLES = conv_ctrl_pkg::CONV_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// host pin
	input wire logic conv_start_n,
	// comparator result from the analog core, same clock
	input wire logic [conv_ctrl_pkg::RES_W-1:0] sar_code,
	// status
	output logic busy,
	output logic track_hold,
	output logic powered,
	output logic high_speed,
	output logic [conv_ctrl_pkg::RES_W-1:0] result,
	output logic result_valid
);
	import conv_ctrl_pkg::*;

	logic pin_s1_reg, pin_s2_reg, pin_d_reg;
	logic [CNT_W-1:0] pulse_cnt_reg, pulse_cnt_next;
	logic [CNT_W-1:0] conv_cnt_reg, conv_cnt_next;
	logic gated_d_reg;
	conv_state_e state_reg, state_next;
	conv_status_s stat_reg, stat_next;
	logic [RES_W-1:0] result_reg, result_next;
	logic valid_reg, valid_next;

	wire pin_rise = pin_s2_reg & ~pin_d_reg;
	wire pulse_on = (pulse_cnt_reg != '0);
	// gated start is high while either the pin or the pulse is high
	wire gated = pin_s2_reg | pulse_on;
	// the later of the two falling edges starts the conversion
	wire gated_fall = gated_d_reg & ~gated;
	wire conv_done = (state_reg == ST_CONV) && (conv_cnt_reg == CNT_W'(1));
	// a fall while converting or while powered down is dropped
	wire start_conv = gated_fall && (state_reg != ST_CONV) && stat_reg.powered;

	// pin crosses from the host domain through two flops
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			pin_d_reg <= 1'b0;
			gated_d_reg <= 1'b0;
		end else begin
			pin_s1_reg <= conv_start_n;
			pin_s2_reg <= pin_s1_reg;
			pin_d_reg <= pin_s2_reg;
			gated_d_reg <= gated;
		end
	end

	always_comb begin
		pulse_cnt_next = pulse_cnt_reg;
		if (pin_rise) begin
			pulse_cnt_next = CNT_W'(PWRUP_CYCLES);
		end else if (pulse_on) begin
			pulse_cnt_next = pulse_cnt_reg - CNT_W'(1);
		end
	end

	always_comb begin
		state_next = state_reg;
		stat_next = stat_reg;
		conv_cnt_next = conv_cnt_reg;
		result_next = result_reg;
		valid_next = valid_reg;
		case (state_reg)
			ST_DOWN: begin
				// power-up starts with the internal pulse
				if (pin_rise) begin
					state_next = ST_UP;
					stat_next.powered = 1'b1;
				end
			end
			ST_UP: begin
				if (start_conv) begin
					state_next = ST_CONV;
					conv_cnt_next = CNT_W'(CONV_CYCLES);
					stat_next.busy = 1'b1;
					stat_next.hold = 1'b1;
					valid_next = 1'b0;
				end
			end
			ST_CONV: begin
				if (conv_done) begin
					stat_next.busy = 1'b0;
					stat_next.hold = 1'b0;
					result_next = sar_code;
					valid_next = 1'b1;
					stat_next.hs_mode = pin_s2_reg;
					if (pin_s2_reg) begin
						state_next = ST_UP;
					end else begin
						state_next = ST_DOWN;
						stat_next.powered = 1'b0;
					end
				end else begin
					conv_cnt_next = conv_cnt_reg - CNT_W'(1);
				end
			end
			default: begin
				state_next = ST_DOWN;
				stat_next = '0;
			end
		endcase
	end

	// reset lands in power-down with nothing converting
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= ST_DOWN;
			stat_reg <= '0;
			pulse_cnt_reg <= '0;
			conv_cnt_reg <= '0;
			result_reg <= RES_RST;
			valid_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			stat_reg <= stat_next;
			pulse_cnt_reg <= pulse_cnt_next;
			conv_cnt_reg <= conv_cnt_next;
			result_reg <= result_next;
			valid_reg <= valid_next;
		end
	end

	assign busy = stat_reg.busy;
	assign track_hold = stat_reg.hold;
	assign powered = stat_reg.powered;
	assign high_speed = stat_reg.hs_mode;
	assign result = result_reg;
	assign result_valid = valid_reg;

	// assertions
	int unsigned busy_len;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			busy_len <= 0;
		end else begin
			busy_len <= busy ? busy_len + 1 : 0;
		end
	end

	// cycles since the last synced pin rise, saturating well past the pulse
	int up_age;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			up_age <= 0;
		end else if (pin_rise) begin
			up_age <= 1;
		end else if (up_age < 1000) begin
			up_age <= up_age + 1;
		end
	end

	pulse_len_a: assert property (@(posedge mclk) disable iff (!nrst)
		pin_rise |=> pulse_cnt_reg == CNT_W'(PWRUP_CYCLES))
		else $error("internal pulse not loaded");
	pulse_step_a: assert property (@(posedge mclk) disable iff (!nrst)
		(pulse_on && !pin_rise) |=> pulse_cnt_reg == $past(pulse_cnt_reg) - CNT_W'(1))
		else $error("internal pulse cut short");
	powerup_time_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(busy) |-> up_age > PWRUP_CYCLES) else $error("converted before power-up");
	no_early_a: assert property (@(posedge mclk) disable iff (!nrst)
		(gated && !busy) |=> !busy) else $error("conversion while start still high");
	valid_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
		busy |-> !result_valid) else $error("result valid while converting");
	conv_load_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(busy) |-> conv_cnt_reg == CNT_W'(CONV_CYCLES)) else $error("conversion length");
	result_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		(busy && !conv_done) |=> $stable(result)) else $error("result moved mid-conversion");
	powerup_a: assert property (@(posedge mclk) disable iff (!nrst)
		(state_reg == ST_DOWN && pin_rise) |=> powered) else $error("no power-up");
	start_edge_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(busy) |-> $past(gated_fall)) else $error("conversion without falling edge");
	busy_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
		start_conv |=> busy && track_hold) else $error("busy not raised");
	busy_len_a: assert property (@(posedge mclk) disable iff (!nrst)
		busy_len <= CONV_CYCLES) else $error("conversion too long");
	busy_end_a: assert property (@(posedge mclk) disable iff (!nrst)
		conv_done |=> !busy && !track_hold && result_valid) else $error("busy stuck");
	no_conv_down_a: assert property (@(posedge mclk) disable iff (!nrst)
		!powered |-> !busy) else $error("converting while down");
	mode_a: assert property (@(posedge mclk) disable iff (!nrst)
		$fell(busy) |-> high_speed == $past(pin_s2_reg) && powered == high_speed)
		else $error("mode mismatch");
	powersave_a: assert property (@(posedge mclk) disable iff (!nrst)
		(conv_done && !pin_s2_reg) |=> !powered) else $error("no power-down");
	ignore_a: assert property (@(posedge mclk) disable iff (!nrst)
		(busy && gated_fall && !conv_done) |=> busy) else $error("restart while busy");

	hs_cover: cover property (@(posedge mclk) disable iff (!nrst) $fell(busy) && high_speed);
	ps_cover: cover property (@(posedge mclk) disable iff (!nrst) $fell(busy) && !high_speed);
	late_pin_cover: cover property (@(posedge mclk) disable iff (!nrst)
		gated_fall && $past(pin_s2_reg) && !$past(pulse_on));
	ignore_cover: cover property (@(posedge mclk) disable iff (!nrst) busy && gated_fall);
endmodule : adc_conversion_power_control

// ==== logic/conv_ctrl_pkg.sv ====
// constants and carrier types for the conversion and power sequencer
package conv_ctrl_pkg;
	localparam int CLK_MHZ = 50;
	localparam int PWRUP_NS = 1500;
	localparam int CONV_NS = 2300;
	// least time rounds up, longest time rounds down
	localparam int PWRUP_CYC = (PWRUP_NS * CLK_MHZ + 999) / 1000;
	localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
	localparam int CNT_W = 8;
	localparam int RES_W = 10;
	localparam logic [RES_W-1:0] RES_RST = 10'h000;
	typedef enum logic [1:0] {
		ST_DOWN = 2'b00,
		ST_UP = 2'b01,
		ST_CONV = 2'b11
	} conv_state_e;
	typedef struct packed {
		logic busy;
		logic hold;
		logic powered;
		logic hs_mode;
	} conv_status_s;
endpackage : conv_ctrl_pkg

// ==== tb/host_model.sv ====
// host model driving the start pin and honouring acquisition time
`timescale 1ns/1ps
module host_model (
	// clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// bench request and device status
	input wire logic want,
	// lets the bench drop the pin without the acquisition wait
	input wire logic rush,
	input wire logic busy,
	// start pin
	output logic conv_start_n = 1'b0
);
	logic [2:0] idle_reg;
	always @(negedge mclk or negedge nrst) begin
		if (!nrst) begin
			conv_start_n <= 1'b0;
			idle_reg <= 3'h0;
		end else begin
			idle_reg <= busy ? 3'h0 : idle_reg + {2'h0, idle_reg != 3'h7};
			// a fall waits 100 ns after busy drops
			if (want || rush || idle_reg >= 3'h5)
				conv_start_n <= want;
		end
	end
endmodule : host_model

// ==== tb/adc_conversion_power_control_test.sv ====
// self-checking bench for the conversion and power sequencer
`timescale 1ns/1ps
module adc_conversion_power_control_test;
	import conv_ctrl_pkg::*;
	localparam int PW = 4;
	// long enough for a pin pulse to rise and fall inside one conversion
	localparam int CV = 20;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic want = 1'b0;
	logic rush = 1'b0;
	logic poke = 1'b0;
	logic hs = 1'b0;
	logic conv_start_n;
	logic [RES_W-1:0] sar_code = 10'h000;
	logic busy, track_hold, powered, high_speed, result_valid;
	logic [RES_W-1:0] result;
	int fails = 0;
	int cmp_count = 0;
	int seed = 17;
	int n, h;
	always #10 mclk = ~mclk;
	host_model host (.mclk(mclk), .nrst(nrst), .want(want), .rush(rush), .busy(busy),
		.conv_start_n(conv_start_n));
	adc_conversion_power_control #(.PWRUP_CYCLES(PW), .CONV_CYCLES(CV)) uut (.mclk(mclk),
		.nrst(nrst), .conv_start_n(conv_start_n), .sar_code(sar_code), .busy(busy),
		.track_hold(track_hold), .powered(powered), .high_speed(high_speed),
		.result(result), .result_valid(result_valid));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// status expected as busy falls: mode from the pin, back to track, result valid
	function automatic logic [15:0] done_status(input logic pin_hi);
		return 16'({pin_hi, 2'b01});
	endfunction : done_status
	task automatic stop_test;
		$display("fails %0d cmp_count %0d", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic wait_busy(input logic lvl);
		int k;
		k = 0;
		while (busy !== lvl && k < 200) begin
			@(negedge mclk);
			k++;
		end
		if (busy !== lvl) begin
			fails++;
			stop_test();
		end
	endtask : wait_busy
	initial begin
		repeat (4) @(negedge mclk);
		nrst <= 1'b1;
		@(negedge mclk);
		check(16'({busy, powered, result_valid}), 16'h0);
		for (int i = 0; i < 10; i++) begin
			// second pass holds the pin well past the internal pulse
			h = (i == 1) ? 12 : 1 + ($unsigned($random(seed)) % 3);
			sar_code = RES_W'($random(seed));
			want <= 1'b1;
			repeat (h) @(negedge mclk);
			check(16'(busy), 16'h0);
			want <= 1'b0;
			wait_busy(1'b1);
			check(16'({track_hold, result_valid, powered}), 16'h5);
			// every fourth pass pulses the pin while busy; that edge must be dropped
			poke = (i % 4 == 3);
			hs = 1'($random(seed)) & ~poke;
			want <= hs | poke;
			rush <= poke;
			n = 0;
			while (busy === 1'b1 && n < 300) begin
				@(negedge mclk);
				n++;
				if (n == 3)
					want <= hs;
			end
			rush <= 1'b0;
			check(16'(n), 16'(CV));
			check(16'({high_speed, track_hold, result_valid}), done_status(hs));
			check(16'(result), 16'(sar_code));
			@(negedge mclk);
			check(16'(powered), 16'(hs));
		end
		// reset again in mid-conversion: everything must come back powered down
		want <= 1'b1;
		repeat (2) @(negedge mclk);
		want <= 1'b0;
		wait_busy(1'b1);
		nrst <= 1'b0;
		repeat (2) @(negedge mclk);
		nrst <= 1'b1;
		@(negedge mclk);
		check(16'({busy, powered, result_valid, high_speed, track_hold}), 16'h0);
		check(16'(result), 16'(RES_RST));
		stop_test();
	end
endmodule : adc_conversion_power_control_test
